//--- hw/rxf_flag.sv
/*
 * One sticky status flag: set by a hardware event, cleared by software.
 * Assumes set and clear are single-cycle pulses on mclk.
 */
`default_nettype none
module rxf_flag (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output var  logic flag_q
);
  // Set beats a clear in the same cycle so no event is lost
  always_ff @(posedge mclk) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- hw/rxf_pkg.sv
/*
 * Package for the receive status flag block: register offsets, field
 * positions, reset values and frame length limits.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
`default_nettype none
package rxf_pkg;
  // Register byte offsets
  localparam logic [4:0] RXF_OFS_CMD    = 5'h00;  // mac_command_register
  localparam logic [4:0] RXF_OFS_MASK   = 5'h04;  // interrupt_mask_register
  localparam logic [4:0] RXF_OFS_STATUS = 5'h08;  // interrupt_status_register
  localparam logic [4:0] RXF_OFS_MISSED = 5'h0C;  // missed_packet_counter
  localparam logic [4:0] RXF_OFS_LEN    = 5'h10;  // last frame length

  // Command register bit positions
  localparam int RXF_CMD_ACC_SHORT = 0;  // accept_short_frames
  localparam int RXF_CMD_ACC_LONG  = 1;  // accept_long_frames
  localparam int RXF_CMD_ACC_ERR   = 2;  // accept_errored_frames

  // Status and mask bit positions
  localparam int RXF_BIT_IRQ      = 0;  // receive_interrupt summary
  localparam int RXF_BIT_CRC      = 1;  // crc_error_flag
  localparam int RXF_BIT_OVERFLOW = 2;  // fifo_overflow_flag
  localparam int RXF_BIT_TOO_LONG = 3;  // too_long_flag
  localparam int RXF_BIT_GOOD     = 4;  // receive_good_flag
  localparam int RXF_BIT_ALIGN    = 5;  // alignment_error_flag
  localparam int RXF_BIT_RUNT     = 6;  // runt_frame_flag
  localparam int RXF_BIT_MISSED   = 7;  // missed_overflow_flag
  localparam int RXF_FLAG_LO      = 1;
  localparam int RXF_FLAG_HI      = 7;

  // Reset values
  localparam logic [2:0]  RXF_CMD_RST    = 3'h0;
  localparam logic [7:0]  RXF_MASK_RST   = 8'h00;
  localparam logic [15:0] RXF_MISSED_RST = 16'h0000;
  localparam logic [15:0] RXF_LEN_RST    = 16'h0000;

  // Frame length limits in bytes
  localparam logic [15:0] RXF_MIN_FRAME = 16'd64;
  localparam logic [15:0] RXF_MAX_FRAME = 16'd1518;
endpackage
`default_nettype wire

//--- hw/rxf_status.sv
/*
 * Receive status flags of an Ethernet MAC: frame checks at frame end,
 * missed packet counter, sticky write-1-to-clear flags, mask and a level
 * receive interrupt, all reached over an Avalon-MM slave.
 * Assumes the frame stream inputs are on mclk, single-cycle pulses.
 */
// Operation
// - Missed packet counter rolling over sets status bit 7.
// - Frame under 64 bytes without short acceptance is dropped, sets bit 6.
// - With short acceptance on, short frames count good, bit 6 stays clear.
// - Frame length not a whole number of bytes sets bit 5.
// - Completed reception of a frame that is not dropped sets bit 4.
// - Frame over 1518 bytes without long acceptance is dropped, sets bit 3.
// - With long acceptance on, long frames count good, bit 3 stays clear.
// - FIFO overflow during a frame drops it and sets bit 2.
// - CRC-failing frame without error acceptance is dropped, sets bit 1.
// - With error acceptance on, CRC-failing frames count good, bit 1 clear.
// - Any set flag with its mask bit set drives the receive interrupt high.
// - Writing 1 to a flag position clears that flag, unless that flag's set event comes in the same cycle.
// - Interrupt is the OR of status bits ANDed with their enables.
`default_nettype none
module rxf_status
  import rxf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Frame stream
  input  wire logic        rx_byte_valid,
  input  wire logic        rx_frame_end,
  input  wire logic        rx_dribble,
  input  wire logic        rx_crc_ok,
  input  wire logic        rx_fifo_overflow,
  input  wire logic        rx_missed,
  // Frame verdict and interrupt
  output var  logic        rx_frame_accept,
  output var  logic        rx_frame_drop,
  output var  logic        receive_interrupt
);
  import rxf_pkg::*;

  logic        ack_q;
  logic        wr_fire;
  logic        rd_take;
  logic [2:0]  cmd_q;
  logic [7:0]  mask_q;
  logic [7:0]  status;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;
  logic [15:0] missed_q;
  logic [15:0] len_q;
  logic [15:0] last_len_q;
  logic [15:0] len_now;
  logic        in_frame_q;
  logic        ovf_q;
  logic        is_short;
  logic        is_long;
  logic        crc_bad;
  logic        drop_now;
  logic        irq_d;

  // One wait state per access; waitrequest drops on the second cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_fire         = avs_write & ack_q;
  assign rd_take         = avs_read & ~ack_q;

  // Access phase tracker
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // Command register: acceptance controls
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_q <= RXF_CMD_RST;
    end else if (wr_fire && avs_byteenable[0] && avs_address == RXF_OFS_CMD) begin
      cmd_q <= avs_writedata[2:0];
    end
  end

  // Mask register: enables for bits 7..1, bit 0 unused
  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_q <= RXF_MASK_RST;
    end else if (wr_fire && avs_byteenable[0] && avs_address == RXF_OFS_MASK) begin
      mask_q <= {avs_writedata[7:1], 1'b0};
    end
  end

  // Read data latched in the wait cycle, stands when waitrequest is low
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      if (avs_address == RXF_OFS_CMD) begin
        avs_readdata <= {29'h0000_0000, cmd_q};
      end else if (avs_address == RXF_OFS_MASK) begin
        avs_readdata <= {24'h00_0000, mask_q};
      end else if (avs_address == RXF_OFS_STATUS) begin
        avs_readdata <= {24'h00_0000, status};
      end else if (avs_address == RXF_OFS_MISSED) begin
        avs_readdata <= {16'h0000, missed_q};
      end else if (avs_address == RXF_OFS_LEN) begin
        avs_readdata <= {16'h0000, last_len_q};
      end else begin
        avs_readdata <= 32'h0000_0000;  // Unmapped reads as zero
      end
    end
  end

  // Missed packet counter, wraps on overflow
  always_ff @(posedge mclk) begin
    if (rst) begin
      missed_q <= RXF_MISSED_RST;
    end else if (rx_missed) begin
      missed_q <= 16'(missed_q + 16'h0001);
    end
  end

  // Byte counter for the frame in progress, saturating
  always_ff @(posedge mclk) begin
    if (rst) begin
      len_q <= RXF_LEN_RST;
    end else if (rx_frame_end) begin
      len_q <= RXF_LEN_RST;
    end else if (rx_byte_valid && len_q != 16'hFFFF) begin
      len_q <= 16'(len_q + 16'h0001);
    end
  end

  // A byte arriving with the end marker is part of the frame
  assign len_now = (rx_byte_valid && len_q != 16'hFFFF) ? 16'(len_q + 16'h0001) : len_q;

  // Frame activity and overflow seen during it
  always_ff @(posedge mclk) begin
    if (rst) begin
      in_frame_q <= 1'b0;
      ovf_q      <= 1'b0;
    end else if (rx_frame_end) begin
      in_frame_q <= 1'b0;
      ovf_q      <= 1'b0;
    end else begin
      if (rx_byte_valid) begin
        in_frame_q <= 1'b1;
      end
      // Only an overflow inside a frame may spoil that frame's verdict
      if (rx_fifo_overflow && (in_frame_q || rx_byte_valid)) begin
        ovf_q <= 1'b1;
      end
    end
  end

  // Length of the last finished frame, for software
  always_ff @(posedge mclk) begin
    if (rst) begin
      last_len_q <= RXF_LEN_RST;
    end else if (rx_frame_end) begin
      last_len_q <= len_now;
    end
  end

  // Frame checks, length and CRC gated by their acceptance controls, overflow always drops
  assign is_short = (len_now < RXF_MIN_FRAME) & ~cmd_q[RXF_CMD_ACC_SHORT];
  assign is_long  = (len_now > RXF_MAX_FRAME) & ~cmd_q[RXF_CMD_ACC_LONG];
  assign crc_bad  = ~rx_crc_ok & ~cmd_q[RXF_CMD_ACC_ERR];
  assign drop_now = is_short | is_long | crc_bad | ovf_q | rx_fifo_overflow;

  // Verdict pulses one cycle after the end marker
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_frame_accept <= 1'b0;
      rx_frame_drop   <= 1'b0;
    end else begin
      rx_frame_accept <= rx_frame_end & ~drop_now;
      rx_frame_drop   <= rx_frame_end & drop_now;
    end
  end

  // Hardware events that set each flag
  always_comb begin
    flag_set = 8'h00;
    flag_set[RXF_BIT_MISSED]   = rx_missed && missed_q == 16'hFFFF;
    flag_set[RXF_BIT_RUNT]     = rx_frame_end & is_short;
    flag_set[RXF_BIT_ALIGN]    = rx_frame_end & rx_dribble;
    flag_set[RXF_BIT_GOOD]     = rx_frame_end & ~drop_now;
    flag_set[RXF_BIT_TOO_LONG] = rx_frame_end & is_long;
    flag_set[RXF_BIT_OVERFLOW] = rx_fifo_overflow & (in_frame_q | rx_byte_valid);
    flag_set[RXF_BIT_CRC]      = rx_frame_end & crc_bad;
  end

  // Write-1-to-clear; zeros leave flags alone
  always_comb begin
    flag_clr = 8'h00;
    if (wr_fire && avs_byteenable[0] && avs_address == RXF_OFS_STATUS) begin
      flag_clr = avs_writedata[7:0];
    end
  end

  // Sticky flags, bits 7..1
  genvar gi;
  generate
    for (gi = RXF_FLAG_LO; gi <= RXF_FLAG_HI; gi++) begin : g_flag
      rxf_flag u_flag (
        .mclk   (mclk),
        .rst    (rst),
        .set    (flag_set[gi]),
        .clr    (flag_clr[gi]),
        .flag_q (status[gi])
      );
    end
  endgenerate

  // Summary bit reads as the interrupt level
  assign status[RXF_BIT_IRQ] = receive_interrupt;

  // OR of enabled flags
  assign irq_d = |(status[7:1] & mask_q[7:1]);

  // Registered level interrupt
  always_ff @(posedge mclk) begin
    if (rst) begin
      receive_interrupt <= 1'b0;
    end else begin
      receive_interrupt <= irq_d;
    end
  end

  // Checks on the flag and interrupt behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_missed_wrap: assert property (
    rx_missed && missed_q == 16'hFFFF |=> status[RXF_BIT_MISSED] && missed_q == 16'h0000)
    else $error("missed counter wrap did not set flag");

  a_runt_set: assert property (
    rx_frame_end && len_now < RXF_MIN_FRAME && !cmd_q[RXF_CMD_ACC_SHORT]
    |=> status[RXF_BIT_RUNT] && rx_frame_drop && !rx_frame_accept)
    else $error("short frame not flagged and dropped");

  a_runt_accept: assert property (
    rx_frame_end && cmd_q[RXF_CMD_ACC_SHORT] && !status[RXF_BIT_RUNT]
    |=> !status[RXF_BIT_RUNT])
    else $error("runt flag set while short frames accepted");

  a_align_set: assert property (
    rx_frame_end && rx_dribble |=> status[RXF_BIT_ALIGN])
    else $error("alignment error not flagged");

  a_good_set: assert property (
    rx_frame_end && !drop_now |=> status[RXF_BIT_GOOD] && rx_frame_accept)
    else $error("good frame not flagged");

  a_long_set: assert property (
    rx_frame_end && len_now > RXF_MAX_FRAME && !cmd_q[RXF_CMD_ACC_LONG]
    |=> status[RXF_BIT_TOO_LONG] && rx_frame_drop)
    else $error("long frame not flagged and dropped");

  a_long_accept: assert property (
    rx_frame_end && cmd_q[RXF_CMD_ACC_LONG] && !status[RXF_BIT_TOO_LONG]
    |=> !status[RXF_BIT_TOO_LONG])
    else $error("too long flag set while long frames accepted");

  // Overflow handling: in a frame it flags and drops, outside one it is ignored
  a_ovf_drop: assert property (
    rx_frame_end && (ovf_q || (rx_fifo_overflow && rx_byte_valid))
    |=> rx_frame_drop && !rx_frame_accept)
    else $error("overflowed frame not dropped");

  a_ovf_flag: assert property (
    rx_fifo_overflow && rx_byte_valid |=> status[RXF_BIT_OVERFLOW])
    else $error("overflow in a frame not flagged");

  a_ovf_idle: assert property (
    rx_fifo_overflow && !rx_byte_valid && !in_frame_q && !status[RXF_BIT_OVERFLOW]
    |=> !status[RXF_BIT_OVERFLOW] && !ovf_q)
    else $error("overflow outside a frame was recorded");

  a_crc_set: assert property (
    rx_frame_end && !rx_crc_ok && !cmd_q[RXF_CMD_ACC_ERR]
    |=> status[RXF_BIT_CRC] && rx_frame_drop)
    else $error("CRC error frame not flagged and dropped");

  a_crc_accept: assert property (
    rx_frame_end && !rx_crc_ok && cmd_q[RXF_CMD_ACC_ERR] && !status[RXF_BIT_CRC]
    |=> !status[RXF_BIT_CRC])
    else $error("CRC flag set while error frames accepted");

  a_irq_level: assert property (
    |($past(status[7:1]) & $past(mask_q[7:1])) == receive_interrupt)
    else $error("interrupt level does not match enabled flags");

  a_w1c_clear: assert property (
    wr_fire && avs_byteenable[0] && avs_address == RXF_OFS_STATUS
    && avs_writedata[RXF_BIT_GOOD] && !flag_set[RXF_BIT_GOOD]
    |=> !status[RXF_BIT_GOOD] ##1 !receive_interrupt || status[RXF_BIT_GOOD] || |status[7:1])
    else $error("write one did not clear flag");

  a_w0_keep: assert property (
    wr_fire && avs_address == RXF_OFS_STATUS && status[RXF_BIT_CRC]
    && !avs_writedata[RXF_BIT_CRC] |=> status[RXF_BIT_CRC])
    else $error("write zero changed a flag");

  a_wait_one: assert property (
    (avs_read || avs_write) && !ack_q |=> !avs_waitrequest)
    else $error("access not answered after one wait state");

  a_idle_ready: assert property (
    !avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait asked with no access pending");

  // Flag and verdict ordering
  a_set_wins: assert property (
    flag_set[RXF_BIT_GOOD] && flag_clr[RXF_BIT_GOOD] |=> status[RXF_BIT_GOOD])
    else $error("clear beat a flag event in the same cycle");

  a_verdict_once: assert property (
    !(rx_frame_accept && rx_frame_drop))
    else $error("frame both accepted and dropped");

  a_verdict_time: assert property (
    rx_frame_accept || rx_frame_drop |-> $past(rx_frame_end))
    else $error("verdict without a frame end");

  // Main scenarios, for coverage
  c_good_frame: cover property (rx_frame_end && !drop_now ##1 rx_frame_accept);
  c_runt_drop:  cover property (rx_frame_end && is_short ##1 rx_frame_drop);
  c_irq_rise:   cover property (!receive_interrupt ##1 receive_interrupt);
  c_set_clear:  cover property (|(flag_set[7:1] & flag_clr[7:1]));
  c_ovf_drop:   cover property (rx_frame_end && ovf_q ##1 rx_frame_drop);
endmodule
`default_nettype wire

//--- verif/tb_top.sv
/*
 * Self-checking bench for rxf_status: frame verdicts, sticky flags, mask,
 * write-1-to-clear, interrupt level and missed counter roll-over.
 * Assumes rxf_pkg, one 125 MHz clock and a one-wait-state Avalon-MM slave.
 */
`default_nettype none
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %0t %s", $time, m); end end

module tb_top import rxf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rx_byte_valid = 1'b0;
  logic        rx_frame_end = 1'b0;
  logic        rx_dribble = 1'b0;
  logic        rx_crc_ok = 1'b1;
  logic        rx_fifo_overflow = 1'b0;
  logic        rx_missed = 1'b0;
  logic        rx_frame_accept;
  logic        rx_frame_drop;
  logic        receive_interrupt;
  int          fail_count = 0;
  int          num_checks = 0;
  int          m_cmd = 0;
  int          m_msk = 0;
  int          m_st = 0;
  int          lens[4] = '{63, 64, 1518, 1519};

  // Free-running system clock
  always #4 mclk = ~mclk;

  rxf_status DUT (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_byte_valid, .rx_frame_end,
    .rx_dribble, .rx_crc_ok, .rx_fifo_overflow, .rx_missed, .rx_frame_accept,
    .rx_frame_drop, .receive_interrupt);

  // Prints counts and verdict, then ends the run
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One bus access, held until waitrequest is sampled low
  task automatic bus(input bit wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    @(posedge mclk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    // Waits as long as the slave asks; only the watchdog ends a hang
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 4'hF, x);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e, input string m);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, 4'hF, x);
    `CHK(x, e, m)
  endtask

  // Status flags against the model, then the interrupt level
  task automatic chk_st();
    logic [31:0] x;
    bus(1'b0, RXF_OFS_STATUS, 32'h0, 4'hF, x);
    `CHK(x[7:1], 7'(m_st >> 1), "status flags")
    `CHK(x[0], 1'((m_st & m_msk & 'hFE) != 0), "status irq bit")
    repeat (2) @(posedge mclk);
    #1 `CHK(receive_interrupt, 1'((m_st & m_msk & 'hFE) != 0), "irq level")
  endtask

  // Clears flags by writing ones and updates the model
  task automatic clr(input int w);
    wreg(RXF_OFS_STATUS, 32'(w));
    m_st = m_st & ~(w & 'hFE);
  endtask

  // Sends one frame of n bytes and checks the verdict pulse
  task automatic frame(input int n, input bit drib, input bit crc, input bit ovf);
    bit sh;
    bit lg;
    bit ce;
    bit dr;
    sh = (n < 64) && !m_cmd[0];
    lg = (n > 1518) && !m_cmd[1];
    ce = !crc && !m_cmd[2];
    dr = sh || lg || ce || ovf;
    // At most one overflow per frame, as with a raised FIFO threshold
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rx_byte_valid <= 1'b1;
      rx_frame_end <= (i == n - 1);
      rx_dribble <= drib;
      rx_crc_ok <= crc;
      rx_fifo_overflow <= ovf && (i == n / 2);
    end
    @(posedge mclk);
    rx_byte_valid <= 1'b0;
    rx_frame_end <= 1'b0;
    rx_fifo_overflow <= 1'b0;
    m_st = m_st | (sh << 6) | (drib << 5) | (!dr << 4) | (lg << 3) | (ovf << 2) | (ce << 1);
    #1 `CHK(rx_frame_drop, dr, "drop pulse")
    `CHK(rx_frame_accept, !dr, "accept pulse")
    rchk(RXF_OFS_LEN, 32'(n), "frame length");
  endtask

  // Main sequence
  initial begin
    int c;
    logic [31:0] x;
    void'($urandom(50));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rchk(RXF_OFS_CMD, 32'h0, "cmd reset");
    rchk(RXF_OFS_MASK, 32'h0, "mask reset");
    rchk(RXF_OFS_STATUS, 32'h0, "status reset");
    rchk(RXF_OFS_MISSED, 32'h0, "missed reset");
    wreg(5'h14, 32'hFFFFFFFF);
    rchk(5'h14, 32'h0, "unmapped read");
    $display("test reset_values done");
    m_msk = 'hFE;
    wreg(RXF_OFS_MASK, 32'h000000FE);
    for (int k = 0; k < 8; k++) begin
      m_cmd = (k % 2) * 7;
      wreg(RXF_OFS_CMD, 32'(m_cmd));
      frame(lens[k / 2], 1'b0, 1'b1, 1'b0);
      chk_st();
      clr('hFE);
      chk_st();
    end
    $display("test length_bounds done");
    for (int k = 0; k < 6; k++) begin
      m_cmd = (k / 3) * 7;
      wreg(RXF_OFS_CMD, 32'(m_cmd));
      frame(100, k % 3 == 0, k % 3 != 1, k % 3 == 2);
      chk_st();
      clr('hFE);
    end
    @(posedge mclk);
    rx_fifo_overflow <= 1'b1;
    @(posedge mclk);
    rx_fifo_overflow <= 1'b0;
    chk_st();
    $display("test error_codes done");
    for (int k = 0; k < 20; k++) begin
      m_msk = $urandom % 256;
      wreg(RXF_OFS_MASK, 32'(m_msk));
      rchk(RXF_OFS_MASK, 32'(m_msk & 'hFE), "mask readback");
      m_cmd = $urandom % 8;
      wreg(RXF_OFS_CMD, 32'(m_cmd));
      rchk(RXF_OFS_CMD, 32'(m_cmd), "cmd readback");
      c = ($urandom % 4 == 0) ? 1519 + $urandom % 20 : 20 + $urandom % 120;
      frame(c, $urandom % 2, $urandom % 2, $urandom % 4 == 0);
      chk_st();
      clr($urandom % 256);
      chk_st();
    end
    bus(1'b1, RXF_OFS_MASK, 32'h0, 4'h0, x);
    rchk(RXF_OFS_MASK, 32'(m_msk & 'hFE), "masked lane write");
    $display("test random_frames done");
    for (int i = 0; i < 65536; i++) begin
      @(posedge mclk);
      rx_missed <= 1'b1;
      if (i == 4) begin
        @(posedge mclk);
        rx_missed <= 1'b0;
        rchk(RXF_OFS_MISSED, 32'd5, "missed count");
      end
    end
    @(posedge mclk);
    rx_missed <= 1'b0;
    @(posedge mclk);
    rchk(RXF_OFS_MISSED, 32'd0, "missed wrap");
    m_st = m_st | 'h80;
    m_msk = 'h80;
    wreg(RXF_OFS_MASK, 32'h00000080);
    chk_st();
    $display("test missed_rollover done");
    test_done();
  end

  // Watchdog: the tests need about 80,000 cycles, so this only trips on a hang
  initial begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end
endmodule
`default_nettype wire
